/* verilog/tkcc_pkg.sv */
// Overview of operation
// (R1) up to five identical modules, each four keys, own control and registers
// (R2) each module divides its slot clock by 32 with a 5-bit divider
// (R3) 8-bit slot counter starts at preload, overflows after 256-preload units
// (R4) hardware slot overflow sets slot overflow flag and irq request flag
// (R5) software writing one to slot flag leaves irq request untouched
// (R6) slot overflow stops oscillators, counters, dividers and slot counters
// (R7) shared slot select: 0 own slot counter, 1 module zero governs all
// (R8) start low clears c/f counters, function counter, dividers; not slot
// (R9) start rising edge switches on counters, dividers and oscillators together
// (R10) c/f counter overflow sets c/f overflow flag, software clears it
// (R11) function counter overflow sets its flag, software clears it
// (R12) function counter clock: system, half, quarter or eighth
// (R13) 2-bit oscillator frequency select, resets to binary 11
// (R14) function counter freezes on slot overflow, reads zero when start low
// (R15) c/f counters hold after slot overflow, cleared when start low
// (R16) unimplemented global control bits read zero
// (R17) per-module slot clock: reference oscillator or system clock over four
// (R18) separate reference and key oscillator enables per module
// (R19) c/f counter counts selected key oscillator cycles in open window
// (R20) start detected as rising edge of register bit, one-cycle pulse
package tkcc_pkg;
    localparam int TKCC_MODS        = 5;
    localparam int TKCC_DIV_BITS    = 5;
    localparam int TKCC_SLOT_BITS   = 8;
    localparam int TKCC_CNT_BITS    = 16;
    // register byte addresses
    localparam logic [7:0] TKCC_A_PRELOAD = 8'h00;
    localparam logic [7:0] TKCC_A_CTRL_A  = 8'h04;
    localparam logic [7:0] TKCC_A_CTRL_B  = 8'h08;
    localparam logic [7:0] TKCC_A_FCNT_LO = 8'h0c;
    localparam logic [7:0] TKCC_A_FCNT_HI = 8'h10;
    localparam logic [7:0] TKCC_A_MOD0    = 8'h20;
    localparam logic [7:0] TKCC_MOD_STEP  = 8'h20;
    // per-module register indices within a module block
    localparam logic [2:0] TKCC_M_CF_LO   = 3'h0;
    localparam logic [2:0] TKCC_M_CF_HI   = 3'h1;
    localparam logic [2:0] TKCC_M_RC_LO   = 3'h2;
    localparam logic [2:0] TKCC_M_RC_HI   = 3'h3;
    localparam logic [2:0] TKCC_M_CTL_A   = 3'h4;
    localparam logic [2:0] TKCC_M_CTL_B   = 3'h5;
    // global control a bit positions
    localparam int TKCC_B_SLOT_OV  = 6;
    localparam int TKCC_B_START    = 5;
    localparam int TKCC_B_CF_OV    = 4;
    localparam int TKCC_B_FN_OV    = 3;
    localparam int TKCC_B_SHARED   = 2;
    // module control b bit positions
    localparam int TKCC_B_SLOT_CLK = 7;
    localparam int TKCC_B_REF_EN   = 5;
    localparam int TKCC_B_KEY_EN   = 4;
    // reset values, register masks and response codes
    localparam logic [7:0] TKCC_RST_CTRL_A = 8'h00;
    localparam logic [7:0] TKCC_RST_CTRL_B = 8'h03;
    localparam logic [7:0] TKCC_CTRL_A_MSK = 8'h7f;
    localparam logic [7:0] TKCC_CTRL_B_MSK = 8'h03;
    localparam logic [7:0] TKCC_MCTL_B_MSK = 8'hbf;
    localparam logic [7:0] TKCC_RC_HI_MSK  = 8'h03;
    localparam logic [1:0] TKCC_RESP_OK     = 2'h0;
    localparam logic [1:0] TKCC_RESP_SLVERR = 2'h2;
    typedef enum logic [1:0] {
        TKCC_IDLE = 2'b00,
        TKCC_RUN  = 2'b01,
        TKCC_DONE = 2'b11
    } tkcc_state_t;
endpackage : tkcc_pkg

/* verilog/tkcc_slot.sv */
`timescale 1ns/1ps
// one module's measurement window: divider, slot counter and c/f counter
module tkcc_slot
    import tkcc_pkg::*;
(
    input  wire logic                     ref_clk_in,
    input  wire logic                     rst_in,
    input  wire logic                     run_in,
    input  wire logic                     clear_in,
    input  wire logic                     load_in,
    input  wire logic [7:0]               preload_in,
    input  wire logic                     slot_tick_in,
    input  wire logic                     key_tick_in,
    output logic                          slot_ov_out,
    output logic                          cf_ov_out,
    output logic [TKCC_CNT_BITS-1:0]      cf_count_out
);
    logic [TKCC_DIV_BITS-1:0]  div_r;
    logic [TKCC_SLOT_BITS-1:0] slot_r;

    // unit divider, cleared while start is low
    always_ff @(posedge ref_clk_in) begin
        if (rst_in || clear_in)
            div_r <= '0; // [R8]
        else if (run_in && slot_tick_in)
            div_r <= div_r + 1'b1; // [R2]
    end

    // slot counter, loaded at start, never cleared by start low
    always_ff @(posedge ref_clk_in) begin
        if (rst_in)
            slot_r <= '0;
        else if (load_in)
            slot_r <= preload_in; // [R3]
        else if (run_in && slot_tick_in && (&div_r))
            slot_r <= slot_r + 1'b1; // [R3]
    end

    // overflow pulse at last unit
    assign slot_ov_out = run_in && slot_tick_in && (&div_r) && (&slot_r);

    // c/f counter of selected key oscillator
    always_ff @(posedge ref_clk_in) begin
        if (rst_in || clear_in)
            cf_count_out <= '0; // [R15]
        else if (run_in && key_tick_in)
            cf_count_out <= cf_count_out + 1'b1; // [R19]
    end

    assign cf_ov_out = run_in && key_tick_in && (&cf_count_out); // [R10]

    a_div_wraps: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        run_in && slot_tick_in && !clear_in && (div_r == 5'h1f)
        |=> div_r == 5'h00) // [R2]
        else $error("unit divider did not wrap after 32");
    a_cf_hold: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        !run_in && !clear_in |=> $stable(cf_count_out)) // [R15]
        else $error("c/f counter moved while stopped");
endmodule : tkcc_slot

/* verilog/tkcc_top.sv */
// The implementer's own choices: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
// touch key counting and timing control with axi4-lite registers
module tkcc_top
    import tkcc_pkg::*;
#(
    parameter int NUM_MODS = TKCC_MODS
)(
    input  wire logic                  ref_clk_in,
    input  wire logic                  rst_in,
    // axi4-lite slave
    input  wire logic [7:0]            s_axi_awaddr_in,
    input  wire logic                  s_axi_awvalid_in,
    output logic                       s_axi_awready_out,
    input  wire logic [31:0]           s_axi_wdata_in,
    input  wire logic [3:0]            s_axi_wstrb_in,
    input  wire logic                  s_axi_wvalid_in,
    output logic                       s_axi_wready_out,
    output logic [1:0]                 s_axi_bresp_out,
    output logic                       s_axi_bvalid_out,
    input  wire logic                  s_axi_bready_in,
    input  wire logic [7:0]            s_axi_araddr_in,
    input  wire logic                  s_axi_arvalid_in,
    output logic                       s_axi_arready_out,
    output logic [31:0]                s_axi_rdata_out,
    output logic [1:0]                 s_axi_rresp_out,
    output logic                       s_axi_rvalid_out,
    input  wire logic                  s_axi_rready_in,
    // oscillator pins (pulse per cycle, asynchronous)
    input  wire logic [NUM_MODS-1:0]   ref_osc_in,
    input  wire logic [4*NUM_MODS-1:0] key_osc_in,
    // analog controls
    output logic [NUM_MODS-1:0]        ref_osc_run_out,
    output logic [NUM_MODS-1:0]        key_osc_run_out,
    output logic [1:0]                 osc_freq_sel_out,
    output logic [1:0]                 key_mux_sel_out [NUM_MODS],
    output logic [9:0]                 ref_cap_out [NUM_MODS],
    output logic                       touch_irq_request_out
);
    // elaboration check on the module count
    if (NUM_MODS < 1 || NUM_MODS > TKCC_MODS) begin : g_bad_mods
        $error("NUM_MODS must be 1 to 5"); // [R1]
    end

    logic [7:0]  time_slot_preload_r;
    logic [7:0]  ctrl_a_r;
    logic [1:0]  ctrl_b_r;
    logic [15:0] fcnt_r;
    logic        start_d_r;
    logic        start_pulse;
    logic [2:0]  fdiv_r;
    logic        fn_tick;
    logic        fn_ov;
    tkcc_state_t state_r;
    logic        run;
    logic        stop_evt;
    logic [7:0]  mctl_a_r [NUM_MODS];
    logic [7:0]  mctl_b_r [NUM_MODS];
    logic [9:0]  rcap_r [NUM_MODS];
    logic [15:0] cf_cnt [NUM_MODS];
    logic [NUM_MODS-1:0] slot_ov;
    logic [NUM_MODS-1:0] cf_ov;
    logic        any_cf_ov;
    logic        start_bit;
    logic        wr_go;
    logic        aw_held_r;
    logic        w_held_r;
    logic [7:0]  aw_addr_r;
    logic [7:0]  wdat_r;
    logic        wstb_r;

    assign start_bit = ctrl_a_r[TKCC_B_START];

    // start rising edge in system clock domain
    always_ff @(posedge ref_clk_in) begin
        if (rst_in)
            start_d_r <= 1'b0;
        else
            start_d_r <= start_bit;
    end
    assign start_pulse = start_bit && !start_d_r; // [R20]

    // measurement sequencer
    always_ff @(posedge ref_clk_in) begin
        if (rst_in)
            state_r <= TKCC_IDLE;
        else begin
            case (state_r)
                TKCC_IDLE: if (start_pulse) state_r <= TKCC_RUN; // [R9]
                TKCC_RUN: begin
                    if (!start_bit)
                        state_r <= TKCC_IDLE;
                    else if (stop_evt)
                        state_r <= TKCC_DONE; // [R6]
                end
                TKCC_DONE: if (!start_bit) state_r <= TKCC_IDLE;
                default: state_r <= TKCC_IDLE;
            endcase
        end
    end
    assign run = (state_r == TKCC_RUN) && start_bit;

    // window source selection
    assign stop_evt = ctrl_a_r[TKCC_B_SHARED] ? slot_ov[0]
                                              : (|slot_ov); // [R7]

    // function counter clock divider
    always_ff @(posedge ref_clk_in) begin
        if (rst_in || !start_bit)
            fdiv_r <= '0;
        else
            fdiv_r <= fdiv_r + 1'b1;
    end

    // function counter tick select
    always_comb begin
        case (ctrl_a_r[1:0])
            2'h0:    fn_tick = 1'b1; // [R12]
            2'h1:    fn_tick = (fdiv_r[0] == 1'b1);
            2'h2:    fn_tick = (fdiv_r[1:0] == 2'h3);
            default: fn_tick = (fdiv_r == 3'h7);
        endcase
    end

    // function counter, frozen after slot overflow, zero while start low
    always_ff @(posedge ref_clk_in) begin
        if (rst_in || !start_bit)
            fcnt_r <= '0; // [R8] [R14]
        else if (run && fn_tick)
            fcnt_r <= fcnt_r + 1'b1; // [R14]
    end
    assign fn_ov = run && fn_tick && (&fcnt_r); // [R11]

    // per-module oscillator sync, selection and window logic
    genvar m;
    generate
        for (m = 0; m < NUM_MODS; m++) begin : g_mod
            logic [2:0] ref_s_r;
            logic [3:0] key_a_r, key_b_r, key_c_r;
            logic       key_sel;
            logic       ref_tick;
            logic       key_tick;
            logic       slot_tick;
            logic       mod_run;
            logic [1:0] q4_r;

            // key pins are synchronised before the multiplexer reads them
            assign key_sel = key_b_r[mctl_a_r[m][7:6]]
                           && !key_c_r[mctl_a_r[m][7:6]]; // [R19]

            // two-flop sync plus edge stage, every key pin
            always_ff @(posedge ref_clk_in) begin
                if (rst_in) begin
                    ref_s_r <= '0;
                    {key_c_r, key_b_r, key_a_r} <= '0;
                end else begin
                    ref_s_r <= {ref_s_r[1:0], ref_osc_in[m]};
                    {key_c_r, key_b_r, key_a_r} <=
                        {key_b_r, key_a_r, key_osc_in[4*m +: 4]};
                end
            end
            assign ref_tick = ref_s_r[1] && !ref_s_r[2]
                            && mctl_b_r[m][TKCC_B_REF_EN]; // [R18]
            assign key_tick = key_sel && mctl_b_r[m][TKCC_B_KEY_EN]; // [R18]

            // system clock over four
            always_ff @(posedge ref_clk_in) begin
                if (rst_in)
                    q4_r <= '0;
                else
                    q4_r <= q4_r + 1'b1;
            end
            assign slot_tick = mctl_b_r[m][TKCC_B_SLOT_CLK]
                             ? (q4_r == 2'h3) : ref_tick; // [R17]

            assign mod_run = run && !(ctrl_a_r[TKCC_B_SHARED] && m != 0)
                           || run && (m == 0); // [R7]
            assign ref_osc_run_out[m] = run
                && mctl_b_r[m][TKCC_B_REF_EN]; // [R6] [R18]
            assign key_osc_run_out[m] = run
                && mctl_b_r[m][TKCC_B_KEY_EN]; // [R6] [R18]
            assign key_mux_sel_out[m] = mctl_a_r[m][7:6];
            assign ref_cap_out[m]     = rcap_r[m];

            tkcc_slot u_slot (
                .ref_clk_in   (ref_clk_in),
                .rst_in       (rst_in),
                .run_in       (run),
                .clear_in     (!start_bit),
                .load_in      (start_pulse),
                .preload_in   (time_slot_preload_r),
                .slot_tick_in (slot_tick && mod_run),
                .key_tick_in  (key_tick),
                .slot_ov_out  (slot_ov[m]),
                .cf_ov_out    (cf_ov[m]),
                .cf_count_out (cf_cnt[m])
            );
        end
    endgenerate
    assign any_cf_ov = |cf_ov;
    assign osc_freq_sel_out = ctrl_b_r; // [R13]

    // axi write channel capture, either order
    assign s_axi_awready_out = !aw_held_r && !s_axi_bvalid_out;
    assign s_axi_wready_out  = !w_held_r && !s_axi_bvalid_out;
    assign wr_go = aw_held_r && w_held_r;
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            aw_held_r <= 1'b0;
            w_held_r  <= 1'b0;
            aw_addr_r <= '0;
            wdat_r    <= '0;
            wstb_r    <= 1'b0;
        end else if (wr_go) begin
            aw_held_r <= 1'b0;
            w_held_r  <= 1'b0;
        end else begin
            if (s_axi_awvalid_in && s_axi_awready_out) begin
                aw_held_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr_in;
            end
            if (s_axi_wvalid_in && s_axi_wready_out) begin
                w_held_r <= 1'b1;
                wdat_r   <= s_axi_wdata_in[7:0];
                wstb_r   <= s_axi_wstrb_in[0];
            end
        end
    end

    // write response
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            s_axi_bvalid_out <= 1'b0;
            s_axi_bresp_out  <= TKCC_RESP_OK;
        end else if (wr_go) begin
            s_axi_bvalid_out <= 1'b1;
            s_axi_bresp_out  <= (aw_addr_r < TKCC_A_MOD0 + 8'(NUM_MODS) *
                TKCC_MOD_STEP) ? TKCC_RESP_OK : TKCC_RESP_SLVERR;
        end else if (s_axi_bready_in)
            s_axi_bvalid_out <= 1'b0;
    end

    // global registers; hardware set wins over software clear
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            time_slot_preload_r <= '0;
            ctrl_a_r            <= TKCC_RST_CTRL_A;
            ctrl_b_r            <= TKCC_RST_CTRL_B[1:0]; // [R13]
            touch_irq_request_out <= 1'b0;
        end else begin
            if (wr_go && wstb_r) begin
                case (aw_addr_r)
                    TKCC_A_PRELOAD: time_slot_preload_r <= wdat_r;
                    TKCC_A_CTRL_A:  ctrl_a_r <= wdat_r & TKCC_CTRL_A_MSK;
                    TKCC_A_CTRL_B:  ctrl_b_r <= wdat_r[1:0];
                    default: ;
                endcase
            end
            if (run && stop_evt) begin
                ctrl_a_r[TKCC_B_SLOT_OV] <= 1'b1; // [R4]
                touch_irq_request_out    <= 1'b1; // [R4] [R5]
            end
            if (any_cf_ov)
                ctrl_a_r[TKCC_B_CF_OV] <= 1'b1; // [R10]
            if (fn_ov)
                ctrl_a_r[TKCC_B_FN_OV] <= 1'b1; // [R11]
        end
    end

    // module registers
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            for (int i = 0; i < NUM_MODS; i++) begin
                mctl_a_r[i] <= '0;
                mctl_b_r[i] <= '0;
                rcap_r[i]   <= '0;
            end
        end else if (wr_go && wstb_r && aw_addr_r >= TKCC_A_MOD0) begin
            for (int i = 0; i < NUM_MODS; i++) begin
                if (aw_addr_r[7:5] == 3'(i + 1)) begin
                    case (aw_addr_r[4:2])
                        TKCC_M_RC_LO: rcap_r[i][7:0] <= wdat_r;
                        TKCC_M_RC_HI: rcap_r[i][9:8] <= wdat_r[1:0];
                        TKCC_M_CTL_A: mctl_a_r[i] <= wdat_r;
                        TKCC_M_CTL_B: mctl_b_r[i] <=
                                          wdat_r & TKCC_MCTL_B_MSK;
                        default: ;
                    endcase
                end
            end
        end
    end

    // read data mux
    function automatic logic [7:0] rd_byte(input logic [7:0] a);
        logic [7:0] v;
        v = 8'h00;
        case (a)
            TKCC_A_PRELOAD: v = time_slot_preload_r;
            TKCC_A_CTRL_A:  v = ctrl_a_r & TKCC_CTRL_A_MSK; // [R16]
            TKCC_A_CTRL_B:  v = {6'h00, ctrl_b_r}; // [R16]
            TKCC_A_FCNT_LO: v = fcnt_r[7:0];
            TKCC_A_FCNT_HI: v = fcnt_r[15:8];
            default: begin
                for (int i = 0; i < NUM_MODS; i++) begin
                    if (a[7:5] == 3'(i + 1)) begin
                        case (a[4:2])
                            TKCC_M_CF_LO: v = cf_cnt[i][7:0];
                            TKCC_M_CF_HI: v = cf_cnt[i][15:8];
                            TKCC_M_RC_LO: v = rcap_r[i][7:0];
                            TKCC_M_RC_HI: v = {6'h00, rcap_r[i][9:8]};
                            TKCC_M_CTL_A: v = mctl_a_r[i];
                            TKCC_M_CTL_B: v = mctl_b_r[i];
                            default: v = 8'h00;
                        endcase
                    end
                end
            end
        endcase
        return v;
    endfunction

    // read channel
    assign s_axi_arready_out = !s_axi_rvalid_out;
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            s_axi_rvalid_out <= 1'b0;
            s_axi_rdata_out  <= '0;
            s_axi_rresp_out  <= TKCC_RESP_OK;
        end else if (s_axi_arvalid_in && s_axi_arready_out) begin
            s_axi_rvalid_out <= 1'b1;
            s_axi_rdata_out  <= {24'h000000, rd_byte(s_axi_araddr_in)};
            s_axi_rresp_out  <= (s_axi_araddr_in < TKCC_A_MOD0 +
                8'(NUM_MODS) * TKCC_MOD_STEP) ? TKCC_RESP_OK
                                               : TKCC_RESP_SLVERR;
        end else if (s_axi_rready_in)
            s_axi_rvalid_out <= 1'b0;
    end

    a_ov_sets_irq: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        run && stop_evt |=> touch_irq_request_out
        && ctrl_a_r[TKCC_B_SLOT_OV]) // [R4]
        else $error("slot overflow did not raise flags");
    a_ov_stops_run: assert property (@(posedge ref_clk_in)
        disable iff (rst_in)
        run && stop_evt |=> !run ##1 !run) // [R6]
        else $error("window stayed open after overflow");
    a_fcnt_zero: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        !start_bit |=> fcnt_r == 16'h0000) // [R14]
        else $error("function counter not cleared");
    a_fcnt_freeze: assert property (@(posedge ref_clk_in)
        disable iff (rst_in)
        state_r == TKCC_DONE && start_bit |=> $stable(fcnt_r)) // [R14]
        else $error("function counter moved after overflow");
    a_start_pulse: assert property (@(posedge ref_clk_in)
        disable iff (rst_in)
        start_pulse |=> !start_pulse) // [R20]
        else $error("start pulse longer than one cycle");
    a_ctrlb_pad: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        s_axi_rvalid_out && $rose(s_axi_rvalid_out)
        && $past(s_axi_araddr_in) == TKCC_A_CTRL_B
        |-> s_axi_rdata_out[7:2] == 6'h00) // [R16]
        else $error("unimplemented bits read nonzero");
    a_fn_ov_flag: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        fn_ov |=> ctrl_a_r[TKCC_B_FN_OV]) // [R11]
        else $error("function overflow flag not set");
    a_cf_ov_flag: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        any_cf_ov |=> ctrl_a_r[TKCC_B_CF_OV]) // [R10]
        else $error("c/f overflow flag not set");
endmodule : tkcc_top

/* test/tkcc_pads.sv */
`timescale 1ns/1ps
// touch pads sensed through their oscillators, one pulse train per pad
module tkcc_pads #(
    parameter int N = 5
)(
    input  wire logic [N-1:0]   ref_run_in,
    input  wire logic [N-1:0]   key_run_in,
    output logic      [N-1:0]   ref_osc_out,
    output logic      [4*N-1:0] key_osc_out
);
    // reference pads: 80 ns period while enabled, else stand low
    initial begin
        ref_osc_out = '0;
        forever #40 ref_osc_out <= ~ref_osc_out & ref_run_in;
    end
    // every key of a module oscillates while its key oscillator runs
    initial begin
        key_osc_out = '0;
        forever #31 begin
            for (int i = 0; i < 4*N; i++) begin
                key_osc_out[i] <= ~key_osc_out[i] & key_run_in[i/4];
            end
        end
    end
endmodule : tkcc_pads

/* test/tkcc_top_test.sv */
`timescale 1ns/1ps
module tkcc_top_test;
    import tkcc_pkg::*;
    localparam int N = 5;
    logic clk = 0, rst = 1;
    logic [7:0]  awaddr = 0, araddr = 0;
    logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [31:0] wdata = 0, rdata, d, d2;
    logic        awready, wready, bvalid, arready, rvalid, irq;
    logic [1:0]  bresp, rresp, fsel, mux [N];
    logic [9:0]  rcap [N];
    logic [N-1:0]   ref_osc, ref_run, key_run;
    logic [4*N-1:0] key_osc;
    logic [15:0] lfsr = 16'd51690;
    int mismatches = 0, n_compared = 0, n, win, f, e;
    logic [7:0] p;

    // 40 MHz clock
    always #12.5 clk = ~clk;

    tkcc_top #(.NUM_MODS(N)) i_dut (.ref_clk_in(clk), .rst_in(rst),
        .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
        .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
        .s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(wvalid),
        .s_axi_wready_out(wready), .s_axi_bresp_out(bresp),
        .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
        .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
        .s_axi_arready_out(arready), .s_axi_rdata_out(rdata),
        .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
        .s_axi_rready_in(rready), .ref_osc_in(ref_osc),
        .key_osc_in(key_osc), .ref_osc_run_out(ref_run),
        .key_osc_run_out(key_run), .osc_freq_sel_out(fsel),
        .key_mux_sel_out(mux), .ref_cap_out(rcap),
        .touch_irq_request_out(irq));

    tkcc_pads #(.N(N)) i_pads (.ref_run_in(ref_run), .key_run_in(key_run),
        .ref_osc_out(ref_osc), .key_osc_out(key_osc));

    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr_next

    // window in clock cycles: 32 slot clocks per unit, reference pad 3.2
    function automatic int win_cycles(input int pre, input int use_ref);
        return use_ref ? (256 - pre) * 512 / 5 : (256 - pre) * 128;
    endfunction : win_cycles

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // axi write: address and data offered together, each dropped when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        awaddr <= a; wdata <= v; awvalid <= 1; wvalid <= 1; bready <= 1;
        do begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 0;
            if (wvalid && wready) wvalid <= 0;
        end while (!bvalid);
        bready <= 0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk);
        araddr <= a; arvalid <= 1; rready <= 1;
        do begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 0;
        end while (!rvalid);
        v = rdata;
        rready <= 0;
    endtask : rd

    task automatic report_and_stop;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : report_and_stop

    // hang guard, far beyond the four windows of at most 512 cycles each
    initial begin
        repeat (40000) @(posedge clk);
        mismatches++;
        report_and_stop();
    end

    initial begin
        repeat (12) @(posedge clk);
        rst <= 0;
        rd(TKCC_A_CTRL_B, d); chk(d, 32'h3);
        chk(32'(fsel), 32'h3);
        rd(TKCC_A_CTRL_A, d); chk(d, 32'h0);
        wr(TKCC_A_CTRL_B, 32'hffffffff);
        rd(TKCC_A_CTRL_B, d); chk(d, 32'h3);
        lfsr = lfsr_next(lfsr);
        wr(TKCC_A_CTRL_B, {16'h0, lfsr});
        chk(32'(fsel), 32'(lfsr[1:0]));
        // software setting the slot flag must not raise the request
        wr(TKCC_A_CTRL_A, 32'h40);
        chk(32'(irq), 32'h0);
        wr(TKCC_A_CTRL_A, 32'h0);
        rd(8'hfc, d); chk(32'(rresp), 32'(TKCC_RESP_SLVERR));
        for (int sel = 0; sel < 4; sel++) begin
            // module zero, both oscillators on; odd passes clock the slot
            // from the reference pad, even ones from system clock over four
            wr(TKCC_A_MOD0 + 8'h14, (sel & 1) ? 32'h30 : 32'hb0);
            lfsr = lfsr_next(lfsr);
            p = 8'hfc | {6'h0, lfsr[1:0]};
            win = win_cycles(p, sel & 1);
            wr(TKCC_A_PRELOAD, {24'h0, p});
            // start; passes 2 and 3 run on module zero's shared window
            wr(TKCC_A_CTRL_A, 32'h20 | (32'(sel & 2) << 1) | 32'(sel));
            n = 0;
            // window open while the reference oscillator runs
            do begin
                @(posedge clk);
                n++;
            end while (ref_run[0] !== 1'b0 && n < 2000);
            chk(32'(n > win - 24 && n < win + 24), 32'h1);
            chk(32'(key_run), 32'h0);
            chk(32'(irq), 32'h1);
            rd(TKCC_A_CTRL_A, d); chk(d & 32'h40, 32'h40);
            rd(TKCC_A_FCNT_LO, d); rd(TKCC_A_FCNT_HI, d2);
            f = int'({d2[7:0], d[7:0]});
            e = win >> sel;
            chk(32'(f > e - 16 && f < e + 16), 32'h1);
            // c/f count of the first key, pad period 62 ns over the window
            rd(TKCC_A_MOD0, d); rd(TKCC_A_MOD0 + 8'h04, d2);
            f = int'({d2[7:0], d[7:0]});
            e = win * 25 / 62;
            chk(32'(f > e - 8 && f < e + 8), 32'h1);
            rd(TKCC_A_MOD0, d2);
            chk(d2, d);
            // dropping start clears the counters
            wr(TKCC_A_CTRL_A, 32'h04);
            rd(TKCC_A_FCNT_LO, d); chk(d, 32'h0);
            rd(TKCC_A_MOD0, d); chk(d, 32'h0);
        end
        report_and_stop();
    end
endmodule : tkcc_top_test
